// ===== common/cgd_pkg.sv
// Constants, types and helper functions of the clock gate and divider
// control block.
// Assumes a 50 MHz system clock and byte addresses on the register bus.
package cgd_pkg;

  // System clock period and the USB PLL lock wait
  localparam int CLK_PERIOD_NS      = 20;
  localparam int USB_LOCK_TIME_NS   = 300000;
  localparam int USB_LOCK_CYCLES    =
    (USB_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [31:0] GATE_ADDR  = 32'h4C00000C;
  localparam logic [31:0] SLOW_ADDR  = 32'h4C000010;
  localparam logic [31:0] RATIO_ADDR = 32'h4C000014;
  localparam logic [31:0] CAM_ADDR   = 32'h4C000018;

  // Register widths and reset values
  localparam int GATE_W  = 20;
  localparam int SLOW_W  = 8;
  localparam int RATIO_W = 4;
  localparam int CAM_W   = 5;
  localparam logic [19:0] GATE_RST  = 20'hFFFF0;
  localparam logic [7:0]  SLOW_RST  = 8'h04;
  localparam logic [3:0]  RATIO_RST = 4'h0;
  localparam logic [4:0]  CAM_RST   = 5'h00;

  // Field positions in clock_gate_control
  localparam int GATE_CAMERA = 19;
  localparam int GATE_PER_HI = 18;
  localparam int GATE_PER_LO = 7;
  localparam int GATE_RTC    = 14;
  localparam int GATE_USBH   = 6;
  localparam int GATE_LCD    = 5;
  localparam int GATE_NAND   = 4;
  localparam int GATE_SLEEP  = 3;
  localparam int GATE_IDLE   = 2;

  // Field positions in slow_clock_control
  localparam int SLOW_USB_OFF  = 7;
  localparam int SLOW_MPLL_OFF = 5;
  localparam int SLOW_MODE     = 4;
  localparam int SLOW_DIVIDE_VALUE_HI   = 2;

  // Field positions in clock_ratio_control and camera_clock_divider
  localparam int RATIO_USB_HALF = 3;
  localparam int RATIO_SYS_HI   = 2;
  localparam int RATIO_SYS_LO   = 1;
  localparam int RATIO_PER      = 0;
  localparam int CAM_SEL        = 4;
  localparam int CAM_VAL_HI     = 3;

  // Divider slots
  localparam int DIV_W    = 6;
  localparam int NDIV     = 5;
  localparam int DV_SLOW  = 0;
  localparam int DV_SYS   = 1;
  localparam int DV_PER   = 2;
  localparam int DV_USB   = 3;
  localparam int DV_CAM   = 4;

  // PLL formula offsets
  localparam int PLL_M_OFS = 8;
  localparam int PLL_P_OFS = 2;

  // Derived clock ticks, one cycle wide each
  typedef struct packed {
    logic core;
    logic sys_bus;
    logic per_bus;
    logic usb;
    logic camera;
  } cgd_ticks_t;

  // Power and mode requests towards the power sequencer
  typedef struct packed {
    logic main_pll_down;
    logic usb_pll_down;
    logic slow_mode;
    logic sleep_level;
    logic idle_request;
  } cgd_power_t;

  // PLL output frequency from the divider fields
  function automatic longint cgd_pll_out_hz(input longint fin_hz,
                                            input logic [7:0] main_divider_field,
                                            input logic [5:0] pre_divider_field,
                                            input logic [1:0] post_divider_field);
    longint m;
    longint p;
    m = longint'(main_divider_field) + PLL_M_OFS;
    p = (longint'(pre_divider_field) + PLL_P_OFS) << post_divider_field;
    return (m * fin_hz) / p;
  endfunction : cgd_pll_out_hz

endpackage : cgd_pkg

// ===== src/cgd_clock_control.sv
// Clock gate and divider control: registers, tick dividers and gates.
// Assumes all clock sources arrive as one-cycle ticks synchronous to
// clk_sys, and an Avalon-MM master on the register port.
//
// Behaviour
// - System-bus gates: camera, USB host, LCD, NAND
// - Peripheral-bus gates from bits 18 down 7
// - RTC gate stops bus clock only
// - Gate register resets to 0xFFFF0
// - Sleep bit one starts sleep transition
// - Idle bit stays until software clears
// - USB off bit stops clock, PLL down
// - Main PLL off only in slow mode
// - Slow mode core clock from divided input
// - Slow source is crystal or external input
// - Slow divide field resets to four
// - USB clock is PLL or half PLL
// - System-bus ratio codes give 1,2,4,3
// - Peripheral bus equals or halves system bus
// - Camera select picks direct or divided clock
// - Camera divides by twice (field plus one)
// - PLL output follows main, pre, post dividers
// - Idle entry waits for wrapper acknowledge
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps

module cgd_clock_control
  import cgd_pkg::*;
#(
  parameter int USB_LOCK_WAIT = USB_LOCK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        main_pll_tick,
  input  wire logic        usb_pll_tick,
  input  wire logic        crystal_clock_input,
  input  wire logic        external_clock_input,
  input  wire logic        use_external_clock,
  input  wire logic        idle_ack,
  output cgd_ticks_t       clock_ticks,
  output logic      [3:0]  sys_gate_ticks,
  output logic      [11:0] per_gate_ticks,
  output cgd_power_t       power_ctrl,
  output logic             sleep_start,
  output logic             idle_enter,
  output logic             usb_locked
);

  // Control registers
  logic [GATE_W-1:0]  gate_q;
  logic [SLOW_W-1:0]  slow_q;
  logic [RATIO_W-1:0] ratio_q;
  logic [CAM_W-1:0]   cam_q;

  // Bus handshake state
  logic        resp_q;
  logic        req;
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] rdata_d;
  logic [31:0] avs_readdata_q;

  // Clock tree state
  logic             src_tick;
  logic             core_tick;
  logic             usb_src_tick;
  logic             usb_running_q;
  logic [15:0]      lock_cnt_q;
  logic [NDIV-1:0]  div_in;
  logic [NDIV-1:0]  div_out;
  logic [DIV_W-1:0] div_ratio [NDIV];
  cgd_ticks_t       ticks_q;
  logic [3:0]       sys_gate_q;
  logic [11:0]      per_gate_q;
  logic             sleep_start_q;
  logic             idle_enter_q;

  // One wait cycle, then the request is answered at the following edge.
  // The wait cycle gives the read multiplexer a full cycle before the
  // data is registered, so readdata never comes straight from the
  // address decoder. A master that drops its request early simply
  // loses the answer; nothing is left pending here.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~resp_q;
  assign wr_fire         = avs_write & resp_q;
  assign avs_readdata    = avs_readdata_q;

  // Byte enable mask for writes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // Answer pulse, dropped after each served request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= req & ~resp_q;
    end
  end

  // Read multiplexer, reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h00000000;
    unique case (avs_address)
      GATE_ADDR:  rdata_d[GATE_W-1:0]  = gate_q;
      SLOW_ADDR:  rdata_d[SLOW_W-1:0]  = slow_q;
      RATIO_ADDR: rdata_d[RATIO_W-1:0] = ratio_q;
      CAM_ADDR:   rdata_d[CAM_W-1:0]   = cam_q;
      default:    rdata_d = 32'h00000000;
    endcase
  end

  // Read data captured in the wait cycle, stands at the answering edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      avs_readdata_q <= 32'h00000000;
    end else if (avs_read && !resp_q) begin
      avs_readdata_q <= rdata_d;
    end
  end

  // Clock gate register; idle bit is only ever changed by software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_q <= GATE_RST;
    end else if (wr_fire && avs_address == GATE_ADDR) begin
      gate_q <= (gate_q & ~wmask[GATE_W-1:0])
              | (avs_writedata[GATE_W-1:0] & wmask[GATE_W-1:0]);
    end
  end

  // Slow control register; bits 6 and 3 are reserved and hold zero.
  // Leaving slow mode is software's job: it must let the main PLL
  // settle after powering it before the slow bit is cleared, since
  // nothing here holds the core on the slow clock on its own.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slow_q <= SLOW_RST;
    end else if (wr_fire && avs_address == SLOW_ADDR) begin
      slow_q <= ((slow_q & ~wmask[SLOW_W-1:0])
               | (avs_writedata[SLOW_W-1:0] & wmask[SLOW_W-1:0]))
               & 8'hB7;
    end
  end

  // Clock ratio register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ratio_q <= RATIO_RST;
    end else if (wr_fire && avs_address == RATIO_ADDR) begin
      ratio_q <= (ratio_q & ~wmask[RATIO_W-1:0])
               | (avs_writedata[RATIO_W-1:0] & wmask[RATIO_W-1:0]);
    end
  end

  // Camera divider register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cam_q <= CAM_RST;
    end else if (wr_fire && avs_address == CAM_ADDR) begin
      cam_q <= (cam_q & ~wmask[CAM_W-1:0])
             | (avs_writedata[CAM_W-1:0] & wmask[CAM_W-1:0]);
    end
  end

  // Sleep start pulse on a write of one to the sleep bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleep_start_q <= 1'b0;
    end else begin
      sleep_start_q <= wr_fire && avs_address == GATE_ADDR
                       && avs_byteenable[0]
                       && avs_writedata[GATE_SLEEP];
    end
  end

  // Idle entry only after the wrapper acknowledges the request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idle_enter_q <= 1'b0;
    end else begin
      idle_enter_q <= gate_q[GATE_IDLE] & idle_ack;
    end
  end

  // Power requests; main PLL may only go down in slow mode.
  // The off bit alone is only a wish: powering the PLL down while the
  // core still runs from it would stop the core clock outright.
  always_comb begin
    power_ctrl.main_pll_down = slow_q[SLOW_MPLL_OFF]
                               & slow_q[SLOW_MODE];
    power_ctrl.usb_pll_down  = slow_q[SLOW_USB_OFF];
    power_ctrl.slow_mode     = slow_q[SLOW_MODE];
    power_ctrl.sleep_level   = gate_q[GATE_SLEEP];
    power_ctrl.idle_request  = gate_q[GATE_IDLE];
  end

  // USB PLL lock wait after power on, clock held off until it ends.
  // The count restarts whenever the PLL is switched off, so a short
  // off pulse still costs a full lock wait before ticks pass again.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_q    <= 16'h0000;
      usb_running_q <= 1'b0;
    end else if (slow_q[SLOW_USB_OFF]) begin
      lock_cnt_q    <= 16'h0000;
      usb_running_q <= 1'b0;
    end else if (!usb_running_q) begin
      if (lock_cnt_q >= 16'(USB_LOCK_WAIT - 1)) begin
        usb_running_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
    end
  end

  // Source selection: crystal or external input for slow mode
  assign src_tick = use_external_clock ? external_clock_input
                                       : crystal_clock_input;
  // Core clock: PLL in normal mode, divided input in slow mode
  assign core_tick = slow_q[SLOW_MODE] ? div_out[DV_SLOW]
                                       : main_pll_tick;
  // USB PLL ticks only pass once locked and powered
  assign usb_src_tick = usb_pll_tick & usb_running_q;

  // Divider inputs chained from slow source, core and USB sources
  assign div_in[DV_SLOW] = src_tick;
  assign div_in[DV_SYS]  = core_tick;
  assign div_in[DV_PER]  = div_out[DV_SYS];
  assign div_in[DV_USB]  = usb_src_tick;
  assign div_in[DV_CAM]  = usb_src_tick;

  // Requested ratios per divider
  always_comb begin
    if (slow_q[SLOW_DIVIDE_VALUE_HI:0] == 3'h0) begin
      div_ratio[DV_SLOW] = 6'h01;
    end else begin
      div_ratio[DV_SLOW] = {2'h0, slow_q[SLOW_DIVIDE_VALUE_HI:0], 1'b0};
    end
    unique case (ratio_q[RATIO_SYS_HI:RATIO_SYS_LO])
      2'h0: div_ratio[DV_SYS] = 6'h01;
      2'h1: div_ratio[DV_SYS] = 6'h02;
      2'h2: div_ratio[DV_SYS] = 6'h04;
      2'h3: div_ratio[DV_SYS] = 6'h03;
    endcase
    div_ratio[DV_PER] = ratio_q[RATIO_PER] ? 6'h02 : 6'h01;
    div_ratio[DV_USB] = ratio_q[RATIO_USB_HALF] ? 6'h02 : 6'h01;
    if (cam_q[CAM_SEL]) begin
      div_ratio[DV_CAM] = {1'b0, cam_q[CAM_VAL_HI:0], 1'b0}
                          + 6'h02;
    end else begin
      div_ratio[DV_CAM] = 6'h01;
    end
  end

  // Tick dividers; new ratio only taken at a wrap so no runt appears.
  // Each divider counts input ticks and lets the last tick of a period
  // through. After reset the ratio is one until the first output
  // tick, which then loads the programmed ratio.
  for (genvar i = 0; i < NDIV; i++) begin : g_div
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cur_q;
    logic             wrap;

    assign wrap       = (cnt_q + 6'h01) >= cur_q;
    assign div_out[i] = div_in[i] & wrap;

    // Count input ticks, reload ratio at each output tick
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        cnt_q <= 6'h00;
        cur_q <= 6'h01;
      end else if (div_in[i]) begin
        if (wrap) begin
          cnt_q <= 6'h00;
          cur_q <= div_ratio[i];
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  // Registered clock ticks; USB clock stopped while powered off
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ticks_q <= '0;
    end else begin
      ticks_q.core    <= core_tick;
      ticks_q.sys_bus <= div_out[DV_SYS];
      ticks_q.per_bus <= div_out[DV_PER];
      ticks_q.usb     <= div_out[DV_USB];
      ticks_q.camera  <= div_out[DV_CAM];
    end
  end

  // System-bus gates: camera, USB host, LCD, NAND in that order.
  // Gate bits only mask whole ticks, so a gate change never shortens
  // a tick that is already on its way.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sys_gate_q <= 4'h0;
    end else begin
      sys_gate_q <= {4{div_out[DV_SYS]}}
                  & {gate_q[GATE_CAMERA], gate_q[GATE_USBH],
                     gate_q[GATE_LCD], gate_q[GATE_NAND]};
    end
  end

  // Peripheral-bus gates; the RTC gate only stops its bus tick, the
  // timekeeping counter has its own clock and keeps running
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      per_gate_q <= 12'h000;
    end else begin
      per_gate_q <= {12{div_out[DV_PER]}}
                  & gate_q[GATE_PER_HI:GATE_PER_LO];
    end
  end

  // Output assignments
  assign clock_ticks    = ticks_q;
  assign sys_gate_ticks = sys_gate_q;
  assign per_gate_ticks = per_gate_q;
  assign sleep_start    = sleep_start_q;
  assign idle_enter     = idle_enter_q;
  assign usb_locked     = usb_running_q;

endmodule : cgd_clock_control

// ===== verification/cgd_clock_control_monitor.sv
// Assertions on the ports of the clock gate and divider block.
// Assumes one clock domain and a bind to every design instance.
`timescale 1ns/1ps
module cgd_clock_control_monitor
  import cgd_pkg::*;
#(
  parameter int USB_LOCK_WAIT = USB_LOCK_CYCLES
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        idle_ack,
  input wire cgd_ticks_t  clock_ticks,
  input wire cgd_power_t  power_ctrl,
  input wire logic        sleep_start,
  input wire logic        idle_enter,
  input wire logic        usb_locked
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic        gw;
  logic [15:0] run_q;
  // Accepted write to the gate register, low lane
  assign gw = avs_write && !avs_waitrequest && avs_byteenable[0]
              && avs_address == GATE_ADDR;
  // Cycles since the USB PLL was last powered
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) run_q <= '0;
    else if (power_ctrl.usb_pll_down) run_q <= '0;
    else if (!(&run_q)) run_q <= run_q + 16'h0001;
  end
  sequence s_start;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  wait_one_a: assert property (s_start |-> s_one_wait)
    else $error("bus answer not after one wait cycle");
  idle_gate_a: assert property (
    idle_enter |-> $past(idle_ack && power_ctrl.idle_request))
    else $error("idle entered without acknowledge");
  pll_slow_a: assert property (
    power_ctrl.main_pll_down |-> power_ctrl.slow_mode)
    else $error("main PLL down outside slow mode");
  sleep_cause_a: assert property (
    sleep_start |-> $past(gw && avs_writedata[3]))
    else $error("sleep pulse without write");
  usb_quiet_a: assert property (
    power_ctrl.usb_pll_down [*3] |->
      !clock_ticks.usb && !clock_ticks.camera && !usb_locked)
    else $error("USB clock runs while off");
  lock_early_a: assert property (
    usb_locked |-> run_q >= USB_LOCK_WAIT - 2)
    else $error("USB lock before wait");
  lock_late_a: assert property (
    (run_q > USB_LOCK_WAIT) && !power_ctrl.usb_pll_down |-> usb_locked)
    else $error("USB lock missing");
  idle_hold_a: assert property (
    $fell(power_ctrl.idle_request) |-> $past(gw))
    else $error("idle bit cleared by hardware");
endmodule : cgd_clock_control_monitor

bind cgd_clock_control cgd_clock_control_monitor
  #(.USB_LOCK_WAIT(USB_LOCK_WAIT)) u_mon (
  .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .idle_ack(idle_ack),
  .clock_ticks(clock_ticks), .power_ctrl(power_ctrl),
  .sleep_start(sleep_start), .idle_enter(idle_enter),
  .usb_locked(usb_locked));

// ===== verification/cgd_clock_control_test.sv
// Self-checking bench for the clock gate and divider block.
// Assumes PLL and crystal ticks every cycle and a short lock wait.
`timescale 1ns/1ps
module cgd_clock_control_test
  import cgd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_q = 1'b0;
  logic        use_ext_q = 1'b0;
  logic        ack_q = 1'b0;
  logic [3:0]  be_q = 4'hF;
  cgd_ticks_t  clock_ticks;
  logic [3:0]  sys_gate_ticks;
  logic [11:0] per_gate_ticks;
  cgd_power_t  power_ctrl;
  logic        sleep_start;
  logic        idle_enter;
  logic        usb_locked;
  logic [3:0]  sg;
  logic [11:0] pg;
  logic [31:0] d;
  int          err_total = 0;
  int          n_compared = 0;
  int          slp_n = 0;
  int          c[5];
  int          dv[4] = '{1, 2, 4, 3};
  int          cv[3] = '{0, 1, 15};
  logic [31:0] ad[5] = '{GATE_ADDR, SLOW_ADDR, RATIO_ADDR, CAM_ADDR,
                         32'h4C00001C};
  logic [31:0] rv[5] = '{32'hFFFF0, 32'h4, 32'h0, 32'h0, 32'h0};
  logic [31:0] fv[5] = '{32'hFFFFF, 32'hB7, 32'hF, 32'h1F, 32'h0};

  cgd_clock_control #(.USB_LOCK_WAIT(8)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be_q),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_pll_tick(1'b1), .usb_pll_tick(1'b1),
    .crystal_clock_input(1'b1), .external_clock_input(ext_q),
    .use_external_clock(use_ext_q), .idle_ack(ack_q),
    .clock_ticks(clock_ticks), .sys_gate_ticks(sys_gate_ticks),
    .per_gate_ticks(per_gate_ticks), .power_ctrl(power_ctrl),
    .sleep_start(sleep_start), .idle_enter(idle_enter),
    .usb_locked(usb_locked));

  // Clock and sleep pulse counter
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) slp_n <= slp_n + sleep_start;

  task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Counts within one of the expected value pass as exact
  function automatic logic [31:0] nr(int g, int e);
    return (g >= e - 1 && g <= e + 1) ? e : g;
  endfunction : nr

  // Holds the request until waitrequest is seen low at an edge
  task automatic acc();
    int   n;
    logic w;
    n = 0;
    do begin
      #1;
      w = avs_waitrequest;
      d = avs_readdata;
      @(posedge clk_sys);
      n++;
    end while (w !== 1'b0 && n < 50);
    if (n >= 50) chk("bus", 0, 1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : acc

  task automatic wr(logic [31:0] a, logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    acc();
  endtask : wr

  task automatic rd(logic [31:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    acc();
  endtask : rd

  // Counts output ticks over 120 cycles after a settling gap
  task automatic cnt();
    c = '{default: 0};
    sg = '0;
    pg = '0;
    repeat (10) @(posedge clk_sys);
    repeat (120) begin
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 5; i++) c[i] += int'(clock_ticks[i]);
      sg |= sys_gate_ticks;
      pg |= per_gate_ticks;
    end
    @(posedge clk_sys);
  endtask : cnt

  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    int k;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (ad[i]) begin
      rd(ad[i]);
      chk("reset", d, rv[i]);
      wr(ad[i], 32'hFFFFFFFF);
      rd(ad[i]);
      chk("rw", d, fv[i]);
      wr(ad[i], rv[i]);
    end
    chk("pll", 32'(cgd_pll_out_hz(12000000, 8'h5C, 6'h01, 2'h0)),
        32'h17D78400);
    be_q <= 4'h1;
    wr(GATE_ADDR, 32'h00000);
    be_q <= 4'hF;
    rd(GATE_ADDR);
    chk("lane", d, 32'hFFF00);
    wr(GATE_ADDR, 32'hFFFF0);
    k = slp_n;
    wr(GATE_ADDR, 32'hFFFF8);
    repeat (3) @(posedge clk_sys);
    chk("sleep", slp_n - k, 1);
    wr(GATE_ADDR, 32'hFFFF4);
    repeat (3) @(posedge clk_sys);
    chk("noack", idle_enter, 0);
    ack_q <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("idle", idle_enter, 1);
    chk("idlereq", power_ctrl.idle_request, 1);
    rd(GATE_ADDR);
    chk("idlebit", d, 32'hFFFF4);
    ack_q <= 1'b0;
    wr(GATE_ADDR, 32'h84010);
    cnt();
    chk("sysg", sg, 4'h9);
    chk("perg", pg, 12'h080);
    wr(GATE_ADDR, 32'hFFFF0);
    for (int j = 0; j < 4; j++) begin
      wr(RATIO_ADDR, 32'(j << 1));
      cnt();
      chk("sys", nr(c[3], 120 / dv[j]), 120 / dv[j]);
      chk("per", nr(c[2], 120 / dv[j]), 120 / dv[j]);
    end
    wr(RATIO_ADDR, 32'h3);
    cnt();
    chk("perh", nr(c[2], 30), 30);
    wr(SLOW_ADDR, 32'h10);
    cnt();
    chk("slow0", nr(c[4], 120), 120);
    wr(SLOW_ADDR, 32'h12);
    cnt();
    chk("slow2", nr(c[4], 30), 30);
    wr(SLOW_ADDR, 32'h30);
    chk("pdn", power_ctrl.main_pll_down, 1);
    use_ext_q <= 1'b1;
    cnt();
    chk("ext0", c[4], 0);
    ext_q <= 1'b1;
    cnt();
    chk("ext1", nr(c[4], 120), 120);
    wr(SLOW_ADDR, 32'h10);
    chk("pon", power_ctrl.main_pll_down, 0);
    repeat (USB_LOCK_CYCLES) @(posedge clk_sys);
    wr(SLOW_ADDR, 32'h20);
    chk("pup", power_ctrl.main_pll_down, 0);
    wr(SLOW_ADDR, 32'h84);
    cnt();
    chk("updn", power_ctrl.usb_pll_down, 1);
    chk("usb0", c[1], 0);
    chk("cam0", c[0], 0);
    wr(SLOW_ADDR, 32'h04);
    cnt();
    chk("usb", nr(c[1], 120), 120);
    chk("camd", nr(c[0], 120), 120);
    chk("lock", usb_locked, 1);
    wr(RATIO_ADDR, 32'h8);
    cnt();
    chk("usbh", nr(c[1], 60), 60);
    foreach (cv[j]) begin
      wr(CAM_ADDR, 32'h10 | cv[j]);
      cnt();
      chk("cam", nr(c[0], 60 / (cv[j] + 1)), 60 / (cv[j] + 1));
    end
    give_verdict();
  end
endmodule : cgd_clock_control_test
